// ===== hdl/tdc_top.sv
`timescale 1ns/100ps

module tdc_top (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_ext_osc,
	input wire logic i_internal_reference_clock,
	input wire logic i_low_power_osc_1khz,
	output logic [7:0] o_rdata,
	output logic o_irq,
	output logic o_counter_clock_output
);

	typedef struct packed {
		logic module_enable_bit;
		logic [1:0] clock_source_select;
		logic clock_output_enable;
		logic [2:0] prescaler_select;
		logic quarter_second_flag;
		logic one_second_flag;
		logic compare_hit_flag;
		logic quarter_second_irq_enable;
		logic one_second_irq_enable;
		logic compare_irq_enable;
		logic compare_function_enable;
		logic compare_write_complete;
		logic [7:0] compare_value;
		logic [7:0] count;
		logic [tdc_pkg::DIV_W-1:0] prescale;
		logic [7:0] rdata;
		logic irq;
		logic clk_out;
	} tdc_state_t;

	tdc_state_t s;
	tdc_state_t next_s;

	logic ref_raw;
	logic ref_level;
	logic ref_rise;
	logic tick;
	logic hit;
	logic [7:0] count_inc;
	logic [tdc_pkg::DIV_W-1:0] div;
	logic wr_ctrl;
	logic wr_flag;
	logic wr_match;
	logic set_qsec;
	logic set_sec;
	logic set_hit;

	function automatic logic [tdc_pkg::DIV_W-1:0] ps_divisor(
		input logic [2:0] ps
	);
		case (ps)
			3'h0: ps_divisor = tdc_pkg::DIV_PS0;
			3'h1: ps_divisor = tdc_pkg::DIV_PS1;
			3'h2: ps_divisor = tdc_pkg::DIV_PS2;
			3'h3: ps_divisor = tdc_pkg::DIV_PS3;
			3'h4: ps_divisor = tdc_pkg::DIV_PS4;
			3'h5: ps_divisor = tdc_pkg::DIV_PS5;
			3'h6: ps_divisor = tdc_pkg::DIV_PS6;
			default: ps_divisor = tdc_pkg::DIV_PS7;
		endcase
	endfunction

	function automatic logic [7:0] pack_ctrl(input tdc_state_t st);
		logic [7:0] v;
		v = 8'h00;
		v[tdc_pkg::CTRL_EN_BIT] = st.module_enable_bit;
		v[tdc_pkg::CTRL_CLKS_LSB +: 2] = st.clock_source_select;
		v[tdc_pkg::CTRL_CLKEN_BIT] = st.clock_output_enable;
		v[tdc_pkg::CTRL_PS_LSB +: 3] = st.prescaler_select;
		return v;
	endfunction

	function automatic logic [7:0] pack_flag(input tdc_state_t st);
		logic [7:0] v;
		v = 8'h00;
		v[tdc_pkg::FLAG_QSEC_BIT] = st.quarter_second_flag;
		v[tdc_pkg::FLAG_SEC_BIT] = st.one_second_flag;
		v[tdc_pkg::FLAG_HIT_BIT] = st.compare_hit_flag;
		v[tdc_pkg::FLAG_QSEC_IE_BIT] = st.quarter_second_irq_enable;
		v[tdc_pkg::FLAG_SEC_IE_BIT] = st.one_second_irq_enable;
		v[tdc_pkg::FLAG_HIT_IE_BIT] = st.compare_irq_enable;
		v[tdc_pkg::FLAG_HIT_EN_BIT] = st.compare_function_enable;
		v[tdc_pkg::FLAG_WC_BIT] = st.compare_write_complete;
		return v;
	endfunction

	// Selecting among asynchronous pins ahead of the synchroniser; a
	// source switch may cost or add one prescaler count, never a glitch
	// inside this clock domain.
	always_comb begin
		case (tdc_pkg::tdc_src_t'(s.clock_source_select))
			tdc_pkg::TDC_SRC_LPO: ref_raw = i_low_power_osc_1khz;
			tdc_pkg::TDC_SRC_IREF: ref_raw = i_internal_reference_clock;
			tdc_pkg::TDC_SRC_EXT: ref_raw = i_ext_osc;
			default: ref_raw = i_ext_osc;
		endcase
	end

	tdc_ref_sync u_ref_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(ref_raw),
		.o_level(ref_level),
		.o_rise(ref_rise)
	);

	assign div = ps_divisor(s.prescaler_select);
	assign wr_ctrl = i_wr && (i_addr == tdc_pkg::ADDR_CTRL);
	assign wr_flag = i_wr && (i_addr == tdc_pkg::ADDR_FLAG);
	assign wr_match = i_wr && (i_addr == tdc_pkg::ADDR_MATCH);
	assign tick = s.module_enable_bit && ref_rise &&
		(s.prescale >= div - 1'b1);
	assign count_inc = s.count + 8'h01;
	assign hit = tick && s.compare_function_enable &&
		(count_inc[7:2] == s.compare_value[5:0]);
	assign set_qsec = tick;
	assign set_sec = tick && (count_inc[1:0] == 2'h0);
	assign set_hit = hit;

	always_comb begin
		next_s = s;
		next_s.rdata = 8'h00;

		// Prescaler runs only while enabled
		if (s.module_enable_bit && ref_rise) begin
			if (tick) begin
				next_s.prescale = '0;
			end else begin
				next_s.prescale = s.prescale + 1'b1;
			end
		end

		if (tick) begin
			if (hit) begin
				next_s.count = {6'h00, count_inc[1:0]};
			end else begin
				next_s.count = count_inc;
			end
		end

		// Flags set regardless of interrupt enables; set beats clear
		next_s.quarter_second_flag = (s.quarter_second_flag &
			~(wr_flag & i_wdata[tdc_pkg::FLAG_QSEC_BIT])) | set_qsec;
		next_s.one_second_flag = (s.one_second_flag &
			~(wr_flag & i_wdata[tdc_pkg::FLAG_SEC_BIT])) | set_sec;
		next_s.compare_hit_flag = (s.compare_hit_flag &
			~(wr_flag & i_wdata[tdc_pkg::FLAG_HIT_BIT])) | set_hit;

		if (wr_ctrl) begin
			next_s.module_enable_bit = i_wdata[tdc_pkg::CTRL_EN_BIT];
			next_s.clock_source_select =
				i_wdata[tdc_pkg::CTRL_CLKS_LSB +: 2];
			next_s.clock_output_enable = i_wdata[tdc_pkg::CTRL_CLKEN_BIT];
			next_s.prescaler_select = i_wdata[tdc_pkg::CTRL_PS_LSB +: 3];
			// Clear bit is a strobe and reads back as zero
			if (i_wdata[tdc_pkg::CTRL_CLR_BIT]) begin
				next_s.count = tdc_pkg::COUNT_RESET;
				next_s.prescale = '0;
			end
		end

		if (wr_flag) begin
			next_s.quarter_second_irq_enable =
				i_wdata[tdc_pkg::FLAG_QSEC_IE_BIT];
			next_s.one_second_irq_enable = i_wdata[tdc_pkg::FLAG_SEC_IE_BIT];
			next_s.compare_irq_enable = i_wdata[tdc_pkg::FLAG_HIT_IE_BIT];
			next_s.compare_function_enable =
				i_wdata[tdc_pkg::FLAG_HIT_EN_BIT];
		end

		// Write-complete drops for one cycle while a new value lands
		next_s.compare_write_complete = ~wr_match;
		if (wr_match) begin
			next_s.compare_value = i_wdata;
		end

		if (i_rd) begin
			case (i_addr)
				tdc_pkg::ADDR_CTRL: next_s.rdata = pack_ctrl(s);
				tdc_pkg::ADDR_FLAG: next_s.rdata = pack_flag(s);
				tdc_pkg::ADDR_MATCH: next_s.rdata = s.compare_value;
				tdc_pkg::ADDR_COUNT: next_s.rdata = s.count;
				default: next_s.rdata = 8'h00;
			endcase
		end

		next_s.irq =
			(next_s.quarter_second_flag & next_s.quarter_second_irq_enable) |
			(next_s.one_second_flag & next_s.one_second_irq_enable) |
			(next_s.compare_hit_flag & next_s.compare_irq_enable);

		next_s.clk_out = s.clock_output_enable & ref_level;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s <= '0;
			s.clock_source_select <= tdc_pkg::CLKS_RESET;
			s.prescaler_select <= tdc_pkg::PS_RESET;
			s.compare_value <= tdc_pkg::MATCH_RESET;
			s.count <= tdc_pkg::COUNT_RESET;
			s.compare_write_complete <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign o_rdata = s.rdata;
	assign o_irq = s.irq;
	assign o_counter_clock_output = s.clk_out;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	reset_state_a: assert property ($fell(i_reset) |->
		!s.module_enable_bit && s.prescaler_select == 3'h1 &&
		s.clock_source_select == 2'h0 && s.count == 8'h00 &&
		s.compare_value == 8'h00 && !s.compare_function_enable && !o_irq)
		else $error("state after reset is not the default");

	lpo_route_a: assert property (
		s.clock_source_select == 2'b01 |-> ref_raw == i_low_power_osc_1khz)
		else $error("select 01 does not route the low-power oscillator");

	iref_route_a: assert property (
		s.clock_source_select == 2'b10 |->
		ref_raw == i_internal_reference_clock)
		else $error("select 10 does not route the internal reference");

	ps_divide_a: assert property (
		(s.prescaler_select == 3'h0 |-> div == 16'h00fa) and
		(s.prescaler_select == 3'h3 |-> div == 16'h2580))
		else $error("prescaler divisor is wrong for its setting");

	count_clear_a: assert property (
		wr_ctrl && i_wdata[4] |=> s.count == 8'h00 && s.prescale == '0)
		else $error("counter clear did not zero the counter");

	match_reset_a: assert property (
		tick && s.compare_function_enable &&
		count_inc[7:2] == s.compare_value[5:0] |=>
		s.compare_hit_flag && s.count[7:2] == 6'h00)
		else $error("match did not set flag and zero upper bits");

	second_flag_a: assert property (
		tick && s.count[1:0] == 2'h3 |=>
		s.one_second_flag && s.quarter_second_flag && s.count[1:0] == 2'h0)
		else $error("fourth tick did not set the one-second flag");

	no_early_hit_a: assert property (
		!s.compare_function_enable ##1 !$past(wr_flag) |->
		!$rose(s.compare_hit_flag))
		else $error("match flag rose while the match was disabled");

	sec_w1c_a: assert property (
		wr_flag && i_wdata[6] && !set_sec |=> !s.one_second_flag)
		else $error("writing one did not clear the one-second flag");

	flag_sticky_a: assert property (
		s.one_second_flag && !(wr_flag && i_wdata[6]) |=> s.one_second_flag)
		else $error("one-second flag dropped without a clear");

	irq_cause_a: assert property (
		(s.compare_hit_flag && s.compare_irq_enable) ||
		(s.one_second_flag && s.one_second_irq_enable) |-> o_irq)
		else $error("interrupt low while an enabled flag is set");

	irq_sec_a: assert property (
		set_sec && s.one_second_irq_enable && !wr_flag |=> o_irq)
		else $error("counted second raised no interrupt");

	clk_out_off_a: assert property (
		!s.clock_output_enable |=> !o_counter_clock_output)
		else $error("clock driven out while output disabled");

	clk_out_follow_a: assert property (
		s.clock_output_enable |=>
		o_counter_clock_output == $past(ref_level))
		else $error("clock output does not follow the reference");

	qsec_flag_a: assert property (
		tick |=> s.quarter_second_flag)
		else $error("tick did not set the quarter-second flag");

	one_sec_only_a: assert property (
		!s.one_second_flag && !(tick && s.count[1:0] == 2'h3) |=>
		!s.one_second_flag)
		else $error("one-second flag set off the fourth tick");

	qsec_w1c_a: assert property (
		wr_flag && i_wdata[7] && !tick |=> !s.quarter_second_flag)
		else $error("quarter-second flag not cleared by a one");

	hit_w1c_a: assert property (
		wr_flag && i_wdata[5] && !hit |=> !s.compare_hit_flag)
		else $error("match flag not cleared by a one");

	irq_match_a: assert property (
		hit && s.compare_irq_enable && !wr_flag |=> o_irq)
		else $error("enabled match raised no interrupt");

	irq_quiet_a: assert property (
		!(s.quarter_second_flag && s.quarter_second_irq_enable) &&
		!(s.one_second_flag && s.one_second_irq_enable) &&
		!(s.compare_hit_flag && s.compare_irq_enable) |-> !o_irq)
		else $error("interrupt high with no enabled flag set");

	// A disabled module must hold its place, not lose it
	count_freeze_a: assert property (
		!s.module_enable_bit && !wr_ctrl |=>
		$stable(s.count) && $stable(s.prescale))
		else $error("counter moved while the module was disabled");

	rdata_idle_a: assert property (
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data present without a read");

	wc_pulse_a: assert property (
		(wr_match |=> !s.compare_write_complete) and
		(!wr_match |=> s.compare_write_complete))
		else $error("write-complete bit out of step with writes");

endmodule

// ===== hdl/tdc_pkg.sv
package tdc_pkg;

	// Register map, one byte register per address
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_FLAG = 3'h1;
	localparam logic [2:0] ADDR_MATCH = 3'h2;
	localparam logic [2:0] ADDR_COUNT = 3'h3;

	// counter_control fields
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_CLKS_LSB = 5;
	localparam int CTRL_CLR_BIT = 4;
	localparam int CTRL_CLKEN_BIT = 3;
	localparam int CTRL_PS_LSB = 0;

	// flag_and_irq_control fields
	localparam int FLAG_QSEC_BIT = 7;
	localparam int FLAG_SEC_BIT = 6;
	localparam int FLAG_HIT_BIT = 5;
	localparam int FLAG_QSEC_IE_BIT = 4;
	localparam int FLAG_SEC_IE_BIT = 3;
	localparam int FLAG_HIT_IE_BIT = 2;
	localparam int FLAG_HIT_EN_BIT = 1;
	localparam int FLAG_WC_BIT = 0;

	// Reset values
	localparam logic [2:0] PS_RESET = 3'h1;
	localparam logic [1:0] CLKS_RESET = 2'h0;
	localparam logic [7:0] MATCH_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	typedef enum logic [1:0] {
		TDC_SRC_EXT = 2'b00,
		TDC_SRC_LPO = 2'b01,
		TDC_SRC_IREF = 2'b10,
		TDC_SRC_EXT_ALT = 2'b11
	} tdc_src_t;

	// Reference frequencies and quarter-second division
	localparam int EXT_HZ = 32768;
	localparam int IREF_HZ = 38400;
	localparam int LPO_HZ = 1000;
	localparam int QSEC_PER_SEC = 4;
	localparam int DIV_W = 16;

	localparam logic [DIV_W-1:0] DIV_PS0 = DIV_W'(LPO_HZ / QSEC_PER_SEC);
	localparam logic [DIV_W-1:0] DIV_PS1 = DIV_W'(EXT_HZ / QSEC_PER_SEC);
	localparam logic [DIV_W-1:0] DIV_PS2 = 16'h1000;
	localparam logic [DIV_W-1:0] DIV_PS3 = DIV_W'(IREF_HZ / QSEC_PER_SEC);
	localparam logic [DIV_W-1:0] DIV_PS4 = 16'h01f4;
	localparam logic [DIV_W-1:0] DIV_PS5 = 16'h03e8;
	localparam logic [DIV_W-1:0] DIV_PS6 = 16'h07d0;
	localparam logic [DIV_W-1:0] DIV_PS7 = 16'h4000;

endpackage

// ===== hdl/tdc_ref_sync.sv
`timescale 1ns/100ps

module tdc_ref_sync (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise
);

	typedef struct packed {
		logic [2:0] shift;
		logic level;
		logic rise;
	} tdc_sync_state_t;

	tdc_sync_state_t s;
	tdc_sync_state_t next_s;

	// The first stage only feeds the second; stages two and three filter
	always_comb begin
		next_s = s;
		next_s.shift = {s.shift[1:0], i_async};
		next_s.rise = 1'b0;
		if (s.shift[1] == s.shift[2]) begin
			next_s.level = s.shift[2];
			next_s.rise = s.shift[2] & ~s.level;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_level = s.level;
	assign o_rise = s.rise;

endmodule

// ===== bench/tdc_testbench.sv
`timescale 1ns/100ps

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s expected %h seen %h", nm, e, g); end end

module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_ext_osc = 1'b0;
	logic i_internal_reference_clock = 1'b0;
	logic i_low_power_osc_1khz = 1'b0;
	logic [7:0] o_rdata;
	logic o_irq;
	logic o_counter_clock_output;
	int failures = 0;
	int n_checks = 0;
	int cyc;
	logic found;
	logic rd_q = 1'b0;
	logic clkout_off = 1'b1;
	logic [2:0] ph = 3'h0;
	logic lpo_run = 1'b1;
	logic iref_run = 1'b0;
	logic ext_run = 1'b0;
	logic [7:0] mval;
	logic [7:0] exp_q[$];
	string nm_q[$];
	logic [7:0] exp_v;
	string nm_v;
	// Each row: ctrl value, then {irq expected, ext, iref, lpo running}
	logic [7:0] t_ctrl[4] = '{8'hd0, 8'hb0, 8'hb0, 8'h90};
	logic [3:0] t_run[4] = '{4'b1010, 4'b0010, 4'b1001, 4'b1100};

	tdc_top dut (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.i_ext_osc(i_ext_osc),
		.i_internal_reference_clock(i_internal_reference_clock),
		.i_low_power_osc_1khz(i_low_power_osc_1khz),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_counter_clock_output(o_counter_clock_output)
	);

	always #5 i_clk = ~i_clk;

	// References run 4 cycles high, 4 low; a stopped one rests low
	always @(posedge i_clk) begin
		ph <= ph + 3'h1;
		i_low_power_osc_1khz <= lpo_run & ph[2];
		i_internal_reference_clock <= iref_run & ph[2];
		i_ext_osc <= ext_run & ph[2];
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge i_clk) begin
		rd_q <= i_rd;
		if (rd_q) begin
			// Pop once here: the macro evaluates its arguments twice
			exp_v = exp_q.pop_front();
			nm_v = nm_q.pop_front();
			`CHK(nm_v, exp_v, o_rdata)
		end
		if (clkout_off) begin
			`CHK("clock out idle", 1'b0, o_counter_clock_output)
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
		exp_q.push_back(e);
		nm_q.push_back(n);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		@(posedge i_clk);
	endtask

	task automatic wait_irq(input int bound, output logic hit, output int n);
		hit = 1'b0;
		for (n = 0; n < bound && !hit; n++) begin
			@(posedge i_clk);
			hit = (o_irq === 1'b1);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(56));
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		rd(tdc_pkg::ADDR_CTRL, 8'h01, "ctrl reset");
		rd(tdc_pkg::ADDR_FLAG, 8'h01, "flag reset");
		rd(tdc_pkg::ADDR_MATCH, 8'h00, "match reset");
		rd(tdc_pkg::ADDR_COUNT, 8'h00, "count reset");
		rd(3'h5, 8'h00, "unmapped");
		wr(tdc_pkg::ADDR_CTRL, 8'h4b);
		rd(tdc_pkg::ADDR_CTRL, 8'h4b, "ctrl iref ps3");
		// Match after one second keeps the run short; top bits are random
		mval = {2'($urandom), 6'h01};
		wr(tdc_pkg::ADDR_MATCH, mval);
		rd(tdc_pkg::ADDR_MATCH, mval, "match value");
		wr(tdc_pkg::ADDR_FLAG, 8'hee);
		wr(tdc_pkg::ADDR_CTRL, 8'hb0);
		// 4 ticks of 250 edges, 8 cycles per edge
		wait_irq(9000, found, cyc);
		`CHK("match irq", 1'b1, found)
		`CHK("match time", 1'b1, (cyc > 7900 && cyc < 8100))
		rd(tdc_pkg::ADDR_COUNT, 8'h00, "count after match");
		rd(tdc_pkg::ADDR_FLAG, 8'hef, "flags at match");
		wr(tdc_pkg::ADDR_FLAG, 8'hee);
		`CHK("irq cleared", 1'b0, o_irq)
		wr(tdc_pkg::ADDR_FLAG, 8'he0);
		wait_irq(2500, found, cyc);
		`CHK("masked irq", 1'b0, found)
		rd(tdc_pkg::ADDR_FLAG, 8'h81, "masked flag");
		wr(tdc_pkg::ADDR_FLAG, 8'h10);
		`CHK("unmasked irq", 1'b1, o_irq)
		rd(tdc_pkg::ADDR_COUNT, 8'h01, "count running");
		wr(tdc_pkg::ADDR_CTRL, 8'hb0);
		rd(tdc_pkg::ADDR_COUNT, 8'h00, "count cleared");
		clkout_off <= 1'b0;
		wr(tdc_pkg::ADDR_CTRL, 8'hb8);
		found = 1'b0;
		for (int n = 0; n < 40 && !found; n++) begin
			@(posedge i_clk);
			found = (o_counter_clock_output === 1'b1);
		end
		`CHK("clock out on", 1'b1, found)
		// Only the selected reference may advance the counter
		for (int k = 0; k < 4; k++) begin
			{ext_run, iref_run, lpo_run} <= t_run[k][2:0];
			wr(tdc_pkg::ADDR_CTRL, t_ctrl[k]);
			clkout_off <= 1'b1;
			wr(tdc_pkg::ADDR_FLAG, 8'hf0);
			wait_irq(2600, found, cyc);
			`CHK("source routing", t_run[k][3], found)
		end
		report_and_stop();
	end
endmodule
